// ---- core/phy_irq_status_control_regs.sv ----
// Management register bank: interrupts, loopback, cable test, soft resets
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module phy_irq_status_control_regs
  import phy_regs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output      logic        mdio_out,
  output      logic        mdio_oe,
  input  wire logic [4:0]  strap_addr_pin,
  input  wire logic [7:0]  event_a,
  input  wire logic [7:0]  event_b,
  input  wire logic [7:0]  event_c,
  input  wire logic        link_up,
  input  wire logic        duplex_full,
  input  wire logic        mii_loop_active,
  input  wire logic        prbs_lock_lost,
  input  wire logic        core_normal_power,
  input  wire logic        tdr_busy,
  input  wire logic        tdr_end,
  input  wire logic        tdr_end_fail,
  output      logic        tdr_launch,
  output      logic        core_reset,
  output      logic [6:0]  loopback_select,
  output      logic        dig_pcs_loopback,
  output      logic        irq_pin
);

  // ****************************************************************
  // Pin synchronisers, three stages, change taken when stages 2 and 3 agree
  // ****************************************************************
  logic [2:0] mdc_s_r;
  logic [2:0] mdio_s_r;
  logic       mdc_r;
  logic       mdio_r;
  logic       mdc_q_r;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mdc_s_r  <= 3'h0;
      mdio_s_r <= 3'h7;
      mdc_r    <= 1'b0;
      mdio_r   <= 1'b1;
      mdc_q_r  <= 1'b0;
    end
    else
    begin
      mdc_s_r  <= {mdc_s_r[1:0], mdc};
      mdio_s_r <= {mdio_s_r[1:0], mdio_in};
      if (mdc_s_r[1] == mdc_s_r[2])
        mdc_r <= mdc_s_r[2];
      if (mdio_s_r[1] == mdio_s_r[2])
        mdio_r <= mdio_s_r[2];
      mdc_q_r <= mdc_r;
    end
  end

  logic mdc_rise;
  logic mdc_fall;
  assign mdc_rise = mdc_r & ~mdc_q_r;
  assign mdc_fall = ~mdc_r & mdc_q_r;

  // ****************************************************************
  // Serial management slave, preamble optional
  // ****************************************************************
  mdio_state_e state_r;
  logic [13:0] hdr_r;
  logic [4:0]  cnt_r;
  logic [15:0] shift_r;
  logic        is_read_r;
  logic        wr_stb;
  logic [4:0]  wr_addr_r;
  logic [15:0] wr_data;
  reg_word_t   rd_word;

  // Frame start is a 0 then 1 after idle ones; no preamble count needed. R20
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r   <= MDIO_IDLE;
      hdr_r     <= 14'h0;
      cnt_r     <= 5'h0;
      shift_r   <= 16'h0;
      is_read_r <= 1'b0;
      wr_addr_r <= 5'h0;
      mdio_oe   <= 1'b0;
      mdio_out  <= 1'b1;
    end
    else
    begin
      case (state_r)
        MDIO_IDLE:
        begin
          mdio_oe <= 1'b0;
          if (mdc_rise && !mdio_r)
          begin
            state_r <= MDIO_HDR;
            cnt_r   <= 5'h0;
          end
        end
        MDIO_HDR:
        begin
          if (mdc_rise)
          begin
            hdr_r <= {hdr_r[12:0], mdio_r};
            cnt_r <= cnt_r + 5'h1;
            if (cnt_r == 5'h0 && !mdio_r)
              state_r <= MDIO_IDLE;
            else if (cnt_r == `CNT_HDR_LAST)
            begin
              is_read_r <= hdr_r[10:9] == `OP_READ;
              wr_addr_r <= {hdr_r[3:0], mdio_r};
              state_r   <= MDIO_WAIT;
              cnt_r     <= 5'h0;
            end
          end
        end
        MDIO_WAIT:
        begin
          if (is_read_r)
          begin
            if (mdc_fall)
            begin
              cnt_r <= cnt_r + 5'h1;
              if (cnt_r == `CNT_TA_LAST)
              begin
                mdio_oe  <= 1'b1;
                mdio_out <= rd_word[15];
                shift_r  <= {rd_word[14:0], 1'b0};
                cnt_r    <= 5'h0;
                state_r  <= MDIO_DATA;
              end
            end
          end
          else if (mdc_rise)
          begin
            cnt_r <= cnt_r + 5'h1;
            if (cnt_r == `CNT_TA_LAST)
            begin
              cnt_r   <= 5'h0;
              state_r <= MDIO_DATA;
            end
          end
        end
        MDIO_DATA:
        begin
          if (is_read_r && mdc_fall)
          begin
            cnt_r    <= cnt_r + 5'h1;
            mdio_out <= shift_r[15];
            shift_r  <= {shift_r[14:0], 1'b0};
            if (cnt_r == `CNT_DATA_LAST)
            begin
              mdio_oe <= 1'b0;
              state_r <= MDIO_IDLE;
            end
          end
          else if (!is_read_r && mdc_rise)
          begin
            cnt_r   <= cnt_r + 5'h1;
            shift_r <= {shift_r[14:0], mdio_r};
            if (cnt_r == `CNT_DATA_LAST)
              state_r <= MDIO_IDLE;
          end
        end
        default:
          state_r <= MDIO_IDLE;
      endcase
    end
  end

  assign wr_stb  = (state_r == MDIO_DATA) && !is_read_r && mdc_rise
                   && (cnt_r == `CNT_DATA_LAST);
  assign wr_data = {shift_r[14:0], mdio_r};

  function automatic logic hit(input logic [4:0] ofs);
    hit = wr_stb && (wr_addr_r == ofs);
  endfunction : hit

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic        glob_rst_r;
  logic [15:0] pin_cfg_r;
  logic [7:0]  en_a_r;
  logic [7:0]  en_b_r;
  logic [7:0]  en_c_r;
  logic [7:0]  st_a_r;
  logic [7:0]  st_b_r;
  logic [7:0]  st_c_r;
  logic [7:0]  loop_r;
  logic        prbs_loss_r;
  logic        tdr_auto_r;
  logic        tdr_start_r;
  logic        tdr_done_r;
  logic        tdr_fail_r;
  logic        link_latch_r;
  logic        int_seen_r;
  logic [4:0]  strap_r;
  logic        strap_take_r;
  logic        link_q_r;
  logic        irq_level;

  // Writable fields; global soft reset returns them to defaults. R18
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_cfg_r  <= `RST_PIN_CFG; // R1 R3
      en_a_r     <= 8'h00;
      en_b_r     <= 8'h00;
      en_c_r     <= `RST_IRQ_C_EN; // R7
      loop_r     <= 8'h00;
      tdr_auto_r <= 1'b0;
    end
    else if (glob_rst_r)
    begin
      pin_cfg_r  <= `RST_PIN_CFG; // R18
      en_a_r     <= 8'h00;
      en_b_r     <= 8'h00;
      en_c_r     <= `RST_IRQ_C_EN;
      loop_r     <= 8'h00;
      tdr_auto_r <= 1'b0;
    end
    else
    begin
      if (hit(`OFS_PIN_CFG))
        pin_cfg_r <= wr_data & `MASK_PIN_CFG;
      if (hit(`OFS_IRQ_A))
        en_a_r <= wr_data[7:0]; // R4
      if (hit(`OFS_IRQ_B))
        en_b_r <= wr_data[7:0]; // R5
      if (hit(`OFS_IRQ_C))
        en_c_r <= wr_data[7:0]; // R6
      if (hit(`OFS_LOOP_PWR))
        loop_r <= wr_data[7:0]; // R14
      if (hit(`OFS_TDR))
        tdr_auto_r <= wr_data[`BIT_TDR_AUTO]; // R17
    end
  end

  // Event status bits latch until a global reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_a_r <= 8'h00;
      st_b_r <= 8'h00;
      st_c_r <= 8'h00;
    end
    else if (glob_rst_r)
    begin
      st_a_r <= 8'h00;
      st_b_r <= 8'h00;
      st_c_r <= 8'h00;
    end
    else
    begin
      st_a_r <= st_a_r | (event_a & `MASK_IRQ_A); // R4
      st_b_r <= st_b_r | (event_b & `MASK_IRQ_B); // R5
      st_c_r <= st_c_r | (event_c & `MASK_IRQ_C); // R6
    end
  end

  // Sticky lock loss: set wins over a zero write
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      prbs_loss_r <= 1'b0;
    else if (prbs_lock_lost)
      prbs_loss_r <= 1'b1; // R12
    else if (glob_rst_r)
      prbs_loss_r <= 1'b0;
    else if (hit(`OFS_LOOP_PWR) && !wr_data[`BIT_PRBS_LOSS])
      prbs_loss_r <= 1'b0; // R12
  end

  // Link flag latches low until the summary is read with link up
  logic rd_summary;
  assign rd_summary = (state_r == MDIO_WAIT) && is_read_r && mdc_fall
                      && (cnt_r == `CNT_TA_LAST)
                      && (wr_addr_r == `OFS_SUMMARY);

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_latch_r <= 1'b0;
      int_seen_r   <= 1'b0;
    end
    else
    begin
      if (!link_up || glob_rst_r)
        link_latch_r <= 1'b0; // R9 R18
      else if (rd_summary || link_latch_r)
        link_latch_r <= 1'b1;
      // Global reset wins over the stale pin level of its own cycle
      if (glob_rst_r)
        int_seen_r <= 1'b0; // R18
      else if (irq_level)
        int_seen_r <= 1'b1; // R8
      else if (rd_summary)
        int_seen_r <= 1'b0;
    end
  end

  // Strap captured by a clocked process after reset release
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_r      <= 5'h00;
      strap_take_r <= 1'b1;
    end
    else if (strap_take_r)
    begin
      strap_r      <= strap_addr_pin; // R15
      strap_take_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Cable test and soft resets
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tdr_start_r <= 1'b0;
      tdr_done_r  <= 1'b0;
      tdr_fail_r  <= 1'b0;
      link_q_r    <= 1'b0;
    end
    else
    begin
      link_q_r <= link_up;
      if (hit(`OFS_TDR) && wr_data[`BIT_TDR_START])
        tdr_start_r <= 1'b1; // R16
      else if (tdr_start_r && (tdr_busy || tdr_end))
        tdr_start_r <= 1'b0; // R16
      if (tdr_launch || glob_rst_r)
      begin
        tdr_done_r <= 1'b0;
        tdr_fail_r <= 1'b0;
      end
      if (tdr_end)
      begin
        tdr_done_r <= 1'b1; // R22
        tdr_fail_r <= tdr_end_fail; // R22
      end
    end
  end

  assign tdr_launch = (tdr_start_r && !tdr_busy)
                      || (tdr_auto_r && link_q_r && !link_up); // R17

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      glob_rst_r <= 1'b0;
      core_reset <= 1'b0;
    end
    else
    begin
      glob_rst_r <= hit(`OFS_SWRST) && wr_data[`BIT_GLOBAL_RST];
      core_reset <= hit(`OFS_SWRST) // R19
                    && (wr_data[`BIT_GLOBAL_RST] || wr_data[`BIT_CORE_RST]);
    end
  end

  // ****************************************************************
  // Interrupt pin and outputs
  // ****************************************************************
  logic any_pending;
  assign any_pending = |(st_a_r & en_a_r) | |(st_b_r & en_b_r)
                       | |(st_c_r & en_c_r);
  assign irq_level = pin_cfg_r[`BIT_FORCE]
                     || (pin_cfg_r[`BIT_INT_EN] && any_pending); // R2 R3 R21

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_pin          <= 1'b1;
      loopback_select  <= 7'h00;
      dig_pcs_loopback <= 1'b0;
    end
    else
    begin
      irq_pin          <= irq_level ^ pin_cfg_r[`BIT_POLARITY]; // R1
      loopback_select  <= loop_r[6:0]; // R14
      dig_pcs_loopback <= loop_r[`BIT_DIG_PCS_LOOP];
    end
  end

  // Read mux
  always_comb
  begin
    rd_word = 16'h0000;
    case (wr_addr_r)
      `OFS_SUMMARY:
      begin
        rd_word[`BIT_SUM_INT]    = int_seen_r; // R8
        rd_word[`BIT_SUM_LOOP]   = mii_loop_active; // R11
        rd_word[`BIT_SUM_DUPLEX] = duplex_full; // R10
        rd_word[`BIT_SUM_LINK]   = link_latch_r & link_up; // R9
      end
      `OFS_PIN_CFG: rd_word = pin_cfg_r;
      `OFS_IRQ_A:   rd_word = {st_a_r, en_a_r};
      `OFS_IRQ_B:   rd_word = {st_b_r, en_b_r};
      `OFS_IRQ_C:   rd_word = {st_c_r, en_c_r};
      `OFS_LOOP_PWR:
      begin
        rd_word[7:0]            = loop_r;
        rd_word[`BIT_PRBS_LOSS] = prbs_loss_r;
        rd_word[`BIT_CORE_PWR]  = core_normal_power; // R13
      end
      `OFS_STRAP: rd_word[4:0] = strap_r; // R15
      `OFS_TDR:
      begin
        rd_word[`BIT_TDR_START] = tdr_start_r;
        rd_word[`BIT_TDR_AUTO]  = tdr_auto_r;
        rd_word[`BIT_TDR_DONE]  = tdr_done_r;
        rd_word[`BIT_TDR_FAIL]  = tdr_fail_r;
      end
      default: rd_word = 16'h0000;
    endcase
  end

endmodule : phy_irq_status_control_regs

// ---- include/phy_regs_map.svh ----
// Register offsets, field positions and reset values of the status bank
// ****************************************************************
// Functional notes
// R1: Interrupt polarity bit resets to 1; 1 drives pin active low, 0 high.
// R2: Force bit 2 drives the interrupt pin asserted regardless of events.
// R3: Global interrupt enable resets to 1; when 0, events never assert pin.
// R4: Register A: status upper byte, enables lower byte; link quality etc.
// R5: Register B: voltage, temperature, sleep, polarity, not-one-hot events.
// R6: Register C: ack, tx-valid clear, reset done, no frame, wake, power.
// R7: Reset-done enable resets to 1, register C resets to 0008h.
// R8: Bit 7 of summary shows the interrupt pin has been asserted.
// R9: Bit 0 of summary reads 1 only while link up; drop is latched.
// R10: Duplex bit resets to 1; 1 full duplex, 0 half duplex.
// R11: Bit 3 reads 1 while interface loopback is active.
// R12: Sticky pattern-lock-lost bit 10 set on lock loss; zero write clears.
// R13: Bit 8 reads 1 when the core is in normal power mode.
// R14: Seven-bit one-hot loopback selector plus bit 7 digital loopback enable.
// R15: Strapped five-bit station address latched at reset, read in bits 4-0.
// R16: Writing 1 to bit 15 starts cable test; bit self-clears once running.
// R17: Auto-run bit 14 starts cable test on every link-down event.
// R18: Self-clearing bit 15 resets core and register file to defaults; the cable-test start bit tdr_start_r is not cleared.
// R19: Self-clearing bit 14 resets only the core, registers kept.
// R20: Management frames without preamble are accepted.
// R21: Pin asserts when global enable and any enabled status bit set.
// R22: At test end, set done status, and fail status if run failed.
// ****************************************************************
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH
`define OFS_SUMMARY      5'h10
`define OFS_PIN_CFG      5'h11
`define OFS_IRQ_A        5'h12
`define OFS_IRQ_B        5'h13
`define OFS_LOOP_PWR     5'h16
`define OFS_IRQ_C        5'h18
`define OFS_STRAP        5'h19
`define OFS_TDR          5'h1E
`define OFS_SWRST        5'h1F
`define RST_PIN_CFG      16'h000B
`define RST_IRQ_C_EN     8'h08
`define BIT_POLARITY     3
`define BIT_FORCE        2
`define BIT_INT_EN       1
`define BIT_SUM_INT      7
`define BIT_SUM_LOOP     3
`define BIT_SUM_DUPLEX   2
`define BIT_SUM_LINK     0
`define BIT_PRBS_LOSS    10
`define BIT_CORE_PWR     8
`define BIT_DIG_PCS_LOOP 7
`define BIT_TDR_START    15
`define BIT_TDR_AUTO     14
`define BIT_TDR_DONE     1
`define BIT_TDR_FAIL     0
`define BIT_GLOBAL_RST   15
`define BIT_CORE_RST     14
`define MASK_IRQ_A       8'hEC
`define MASK_IRQ_B       8'hCF
`define MASK_IRQ_C       8'hCF
`define MASK_PIN_CFG     16'hF77F
`define CNT_HDR_LAST     5'hC
`define CNT_TA_LAST      5'h1
`define CNT_DATA_LAST    5'hF
`define OP_READ          2'h2
`endif

// ---- include/phy_regs_pkg.sv ----
// Types shared by the status bank
package phy_regs_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [4:0]  reg_addr_t;
  typedef enum logic [3:0] {
    MDIO_IDLE = 4'h1,
    MDIO_HDR  = 4'h2,
    MDIO_DATA = 4'h4,
    MDIO_WAIT = 4'h8
  } mdio_state_e;
endpackage : phy_regs_pkg

// ---- verification/phy_irq_status_control_regs_properties.sv ----
// Port-level checks of the management register bank
`timescale 1ns/1ps
module phy_regs_checker (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       mdc,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic       link_up,
  input wire logic       tdr_busy,
  input wire logic       tdr_launch,
  input wire logic       core_reset,
  input wire logic [6:0] loopback_select,
  input wire logic       dig_pcs_loopback,
  input wire logic       irq_pin
);
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_reset_quiet: assert property (
    $rose(arst_n) |-> irq_pin && !mdio_oe && !core_reset
    && loopback_select == 7'h00 && !dig_pcs_loopback)
    else $error("outputs not idle after reset");
  a_rst_one_cycle: assert property (
    core_reset |=> !core_reset)
    else $error("core reset held too long");
  a_rst_not_read: assert property (
    core_reset |-> !mdio_oe)
    else $error("core reset during a read");
  a_read_burst_len: assert property (
    $rose(mdio_oe) |-> mdio_oe[*8])
    else $error("read burst too short");
  a_out_on_fall: assert property (
    mdio_oe && $changed(mdio_out) |-> !mdc)
    else $error("read data moved with clock high");
  a_oe_rise_low: assert property (
    $rose(mdio_oe) |-> !mdc)
    else $error("turnaround not on falling clock");
  a_loop_hold_read: assert property (
    mdio_oe |=> $stable(loopback_select) && $stable(dig_pcs_loopback))
    else $error("loopback moved during a read");
  a_no_launch_busy: assert property (
    tdr_busy && link_up && $past(link_up) |-> !tdr_launch)
    else $error("cable test launched while busy");

  c_core_rst: cover property (core_reset);
  c_read: cover property ($rose(mdio_oe));
  c_launch: cover property ($rose(tdr_launch));
  c_irq: cover property ($fell(irq_pin));
endmodule : phy_regs_checker

bind phy_irq_status_control_regs phy_regs_checker chk_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .link_up(link_up), .tdr_busy(tdr_busy),
  .tdr_launch(tdr_launch), .core_reset(core_reset),
  .loopback_select(loopback_select),
  .dig_pcs_loopback(dig_pcs_loopback), .irq_pin(irq_pin));

// ---- verification/mdio_host_model.sv ----
// Management host that sends frames on the serial management pins
`timescale 1ns/1ps
module mdio_host_model #(
  parameter int HALF = 10
) (
  input  wire logic clk,
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output      logic mdc,
  output wire logic mdio_in
);
  // ****************
  // Line and frames
  // ****************
  logic drv_r;
  logic bit_r;

  // Pulled-up line: device, else host, else idle high
  assign mdio_in = mdio_oe ? mdio_out : (drv_r ? bit_r : 1'b1);

  initial
  begin
    mdc = 1'b0;
    drv_r = 1'b0;
    bit_r = 1'b1;
  end

  task automatic tick(input logic b, input logic d, output logic s);
    bit_r = b;
    drv_r = d;
    repeat (HALF) @(negedge clk);
    mdc = 1'b1;
    s = mdio_in;
    repeat (HALF) @(negedge clk);
    mdc = 1'b0;
  endtask : tick

  task automatic frame(input logic rd, input logic [4:0] ad,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, rd, !rd, 5'h00, ad};
    q = 16'h0000;
    for (int i = 13; i >= 0; i--) tick(hdr[i], 1'b1, s);
    tick(1'b1, !rd, s);
    if (!rd) tick(1'b0, 1'b1, s);
    for (int i = 15; i >= 0; i--)
    begin
      tick(wd[i], !rd, s);
      q[i] = s;
    end
    tick(1'b1, 1'b0, s);
    repeat (HALF) @(negedge clk);
  endtask : frame
endmodule : mdio_host_model

// ---- verification/phy_irq_status_control_regs_tb.sv ----
// Self-checking bench for the management register bank
`timescale 1ns/1ps
`include "phy_regs_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module phy_irq_status_control_regs_tb import phy_regs_pkg::*;;
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       mdc, mdio_in, mdio_out, mdio_oe;
  logic [7:0] ev_a = 8'h00, ev_b = 8'h00, ev_c = 8'h00;
  logic       link_up = 1'b1, duplex = 1'b1, mii_loop = 1'b0;
  logic       prbs = 1'b0, pwr = 1'b1, busy = 1'b0;
  logic       tend = 1'b0, tfail = 1'b0, last_launch = 1'b0;
  logic       launch, core_reset, dig_loop, irq_pin;
  logic [6:0] loop_sel;
  logic [4:0] strap = 5'h15;
  reg_word_t  rdv;
  int         err_total = 0, num_checks = 0;
  int         launch_cnt = 0, core_rst_cnt = 0;

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  phy_irq_status_control_regs dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .strap_addr_pin(strap),
    .event_a(ev_a), .event_b(ev_b), .event_c(ev_c), .link_up(link_up),
    .duplex_full(duplex), .mii_loop_active(mii_loop),
    .prbs_lock_lost(prbs), .core_normal_power(pwr), .tdr_busy(busy),
    .tdr_end(tend), .tdr_end_fail(tfail), .tdr_launch(launch),
    .core_reset(core_reset), .loopback_select(loop_sel),
    .dig_pcs_loopback(dig_loop), .irq_pin(irq_pin));
  mdio_host_model host_u (
    .clk(sys_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
    .mdio_in(mdio_in));

  always @(posedge sys_clk)
  begin
    last_launch <= launch;
    if (launch && !last_launch) launch_cnt++;
    if (core_reset) core_rst_cnt++;
  end

  // ****************
  // Helpers
  // ****************
  task automatic end_sim();
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic give_up();
    err_total++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask : give_up

  task automatic wr(input reg_addr_t a, input reg_word_t d);
    reg_word_t q;
    host_u.frame(1'b0, a, d, q);
  endtask : wr

  task automatic rc(input reg_addr_t a, input reg_word_t e);
    reg_word_t q;
    host_u.frame(1'b1, a, 16'h0000, q);
    `CHK(q, e)
  endtask : rc

  task automatic wait_irq(input logic lv);
    for (int i = 0; irq_pin !== lv; i++)
    begin
      if (i == 40) give_up();
      @(negedge sys_clk);
    end
    `CHK(irq_pin, lv)
  endtask : wait_irq

  task automatic wait_launch(input int n);
    for (int i = 0; launch_cnt != n; i++)
    begin
      if (i == 40) give_up();
      @(negedge sys_clk);
    end
    `CHK(launch_cnt, n)
  endtask : wait_launch

  task automatic pulse_ev(input logic [7:0] a, b, c);
    @(negedge sys_clk);
    ev_a = a;
    ev_b = b;
    ev_c = c;
    @(negedge sys_clk);
    ev_a = 8'h00;
    ev_b = 8'h00;
    ev_c = 8'h00;
  endtask : pulse_ev

  // ****************
  // Scenarios
  // ****************
  task automatic s_defaults();
    reg_addr_t a[9] = '{`OFS_PIN_CFG, `OFS_IRQ_A, `OFS_IRQ_B,
      `OFS_LOOP_PWR, `OFS_IRQ_C, `OFS_STRAP, `OFS_TDR, `OFS_SWRST, 5'h14};
    reg_word_t e[9] = '{16'h000B, 16'h0000, 16'h0000, 16'h0100,
      16'h0008, 16'h0015, 16'h0000, 16'h0000, 16'h0000};
    wr(5'h14, 16'hFFFF);
    for (int i = 0; i < 9; i++) rc(a[i], e[i]);
    `CHK(irq_pin, 1'b1)
    strap = 5'h0A;
    rc(`OFS_STRAP, 16'h0015);
    host_u.frame(1'b1, `OFS_SUMMARY, 16'h0000, rdv);
    `CHK(rdv, 16'h0004)
    rc(`OFS_SUMMARY, 16'h0005);
  endtask : s_defaults

  task automatic s_loopback();
    logic [6:0] code[5] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10};
    for (int i = 0; i < 5; i++)
    begin
      wr(`OFS_LOOP_PWR, {8'h00, 1'b1, code[i]});
      `CHK(loop_sel, code[i])
      `CHK(dig_loop, 1'b1)
      rc(`OFS_LOOP_PWR, {8'h01, 1'b1, code[i]});
    end
    pwr = 1'b0;
    prbs = 1'b1;
    mii_loop = 1'b1;
    @(negedge sys_clk);
    prbs = 1'b0;
    rc(`OFS_LOOP_PWR, 16'h0490);
    wr(`OFS_LOOP_PWR, 16'h0000);
    rc(`OFS_LOOP_PWR, 16'h0000);
    rc(`OFS_SUMMARY, 16'h000D);
    mii_loop = 1'b0;
    pwr = 1'b1;
  endtask : s_loopback

  task automatic s_irq();
    wr(`OFS_IRQ_A, 16'h0020);
    pulse_ev(8'h20, 8'h00, 8'h00);
    wait_irq(1'b0);
    rc(`OFS_IRQ_A, 16'h2020);
    rc(`OFS_SUMMARY, 16'h0085);
    wr(`OFS_PIN_CFG, 16'h0003);
    wait_irq(1'b1);
    wr(`OFS_PIN_CFG, 16'h0001);
    wait_irq(1'b0);
    wr(`OFS_PIN_CFG, 16'h0005);
    wait_irq(1'b1);
    wr(`OFS_PIN_CFG, 16'h000B);
  endtask : s_irq

  task automatic s_events();
    wr(`OFS_IRQ_B, 16'h00FF);
    wr(`OFS_IRQ_C, 16'h00FF);
    pulse_ev(8'hFF, 8'hFF, 8'hFF);
    rc(`OFS_IRQ_A, 16'hEC20);
    rc(`OFS_IRQ_B, 16'hCFFF);
    rc(`OFS_IRQ_C, 16'hCFFF);
    wait_irq(1'b0);
  endtask : s_events

  task automatic s_resets();
    wr(`OFS_SWRST, 16'h8000);
    `CHK(core_rst_cnt, 1)
    wait_irq(1'b1);
    rc(`OFS_IRQ_A, 16'h0000);
    rc(`OFS_IRQ_C, 16'h0008);
    rc(`OFS_PIN_CFG, 16'h000B);
    rc(`OFS_SUMMARY, 16'h0004);
    wr(`OFS_LOOP_PWR, 16'h0081);
    wr(`OFS_SWRST, 16'h4000);
    `CHK(core_rst_cnt, 2)
    rc(`OFS_LOOP_PWR, 16'h0181);
    rc(`OFS_SWRST, 16'h0000);
  endtask : s_resets

  task automatic s_tdr();
    wr(`OFS_TDR, 16'h8000);
    wait_launch(1);
    busy = 1'b1;
    rc(`OFS_TDR, 16'h0000);
    tend = 1'b1;
    tfail = 1'b1;
    @(negedge sys_clk);
    tend = 1'b0;
    tfail = 1'b0;
    busy = 1'b0;
    rc(`OFS_TDR, 16'h0003);
    wr(`OFS_TDR, 16'h4000);
    link_up = 1'b0;
    wait_launch(2);
    link_up = 1'b1;
    rc(`OFS_SUMMARY, 16'h0004);
    rc(`OFS_SUMMARY, 16'h0005);
  endtask : s_tdr

  initial
  begin
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    s_defaults();
    s_loopback();
    s_irq();
    s_events();
    s_resets();
    s_tdr();
    end_sim();
  end
endmodule : phy_irq_status_control_regs_tb
